// ==== hw/asm_top.v ====
// arc stage matrix logic with AXI4-Lite register slave
`timescale 1ns/10ps
`include "asm_regs.vh"
module asm_top #(
   parameter AW = 12,
   parameter MS_CYC = `ASM_MS_CYC,
   parameter INSTALL_CYC = `ASM_INSTALL_CYC
) (
   clk,
   rst_n,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   phase_mag,
   resid_mag,
   loop_level,
   goose_in,
   virtual_out,
   light_pin,
   sensor_present_pin,
   ack_pin,
   trip_outputs,
   alarm_relay_output,
   event_valid,
   event_id,
   event_on
);
   input wire clk;
   input wire rst_n;
   input wire [AW-1:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output wire s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output wire s_axi_wready;
   output wire [1:0] s_axi_bresp;
   output wire s_axi_bvalid;
   input wire s_axi_bready;
   input wire [AW-1:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   output wire [31:0] s_axi_rdata;
   output wire [1:0] s_axi_rresp;
   output wire s_axi_rvalid;
   input wire s_axi_rready;
   input wire [9:0] phase_mag;
   input wire [9:0] resid_mag;
   input wire [9:0] loop_level;
   input wire goose_in;
   input wire [5:0] virtual_out;
   input wire [9:0] light_pin;
   input wire [9:0] sensor_present_pin;
   input wire ack_pin;
   output wire [3:0] trip_outputs;
   output wire alarm_relay_output;
   output wire event_valid;
   output wire [3:0] event_id;
   output wire event_on;

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   reg [1:0] rst_sync_q;
   wire rst_l;
   wire [9:0] light_s;
   wire [9:0] present_s;
   wire ack_s;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_l = rst_sync_q[1];

   asm_sync #(.W(21)) u_sync (
      .clk(clk),
      .rst_n(rst_l),
      .pin({ack_pin, sensor_present_pin, light_pin}),
      .sync({ack_s, present_s, light_s})
   );

   // ---------------------------------------------------------------
   // settings
   // ---------------------------------------------------------------
   reg [9:0] ph_start_q;
   reg [9:0] res_start_q;
   reg [9:0] sens_q;
   reg [31:0] evt_en_q;
   reg [23:0] stage_cfg_q [0:7];
   reg [16:0] cur_sel_q [0:7];
   reg [24:0] light_sel_q [0:7];
   reg [8:0] out_cfg_q [0:4];
   reg clear_q;
   reg install_req_q;

   // ---------------------------------------------------------------
   // timebase: 1 ms and 10 ms ticks
   // ---------------------------------------------------------------
   reg [31:0] ms_cnt_q;
   reg [3:0] cs_cnt_q;
   wire ms_tick;
   wire cs_tick;

   assign ms_tick = (ms_cnt_q == MS_CYC - 1);
   assign cs_tick = ms_tick && (cs_cnt_q == `ASM_HOLD_UNIT_MS - 1);
   always @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         ms_cnt_q <= 32'h00000000;
         cs_cnt_q <= 4'h0;
      end else begin
         ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
         if (cs_tick) begin
            cs_cnt_q <= 4'h0;
         end else if (ms_tick) begin
            cs_cnt_q <= cs_cnt_q + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // sensor install and current flags
   // ---------------------------------------------------------------
   reg installing_q;
   reg [31:0] inst_cnt_q;
   reg [9:0] installed_q;
   reg ph_flag_q;
   reg res_flag_q;
   wire [9:0] light_ok;

   always @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         installing_q <= 1'b0;
         inst_cnt_q <= 32'h00000000;
         installed_q <= 10'h000;
         ph_flag_q <= 1'b0;
         res_flag_q <= 1'b0;
      end else begin
         if (install_req_q && !installing_q) begin
            installing_q <= 1'b1;
            inst_cnt_q <= 32'h00000000;
         end else if (installing_q) begin
            if (inst_cnt_q == INSTALL_CYC - 1) begin
               installing_q <= 1'b0;
               installed_q <= present_s;
            end
            inst_cnt_q <= inst_cnt_q + 32'h00000001;
         end
         ph_flag_q <= (phase_mag > ph_start_q);
         res_flag_q <= (resid_mag > res_start_q);
      end
   end

   // sensor 1 is the fibre loop: its level is compared to the sensitivity
   assign light_ok = installed_q &
      {light_s[9:1], light_s[0] | (loop_level >= sens_q)};

   // ---------------------------------------------------------------
   // matrices and stages
   // ---------------------------------------------------------------
   wire [7:0] trip;
   wire [16:0] cur_src;
   wire [24:0] light_src;

   assign cur_src = {trip, virtual_out, goose_in, res_flag_q, ph_flag_q};
   assign light_src = {trip, virtual_out, goose_in, light_ok};

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_stage
         wire cur_none = (cur_sel_q[g] == 17'h00000);
         wire lit_none = (light_sel_q[g] == 25'h0000000);
         wire cur_hit = |(cur_sel_q[g] & cur_src);
         wire lit_hit = |(light_sel_q[g] & light_src);
         // no selection at all leaves the stage idle rather than always on
         wire act = ~(cur_none & lit_none) & (cur_hit | cur_none) &
            (lit_hit | lit_none);
         asm_stage u_stage (
            .clk(clk),
            .rst_n(rst_l),
            .enable(stage_cfg_q[g][`ASM_STG_EN]),
            .act(act),
            .ms_tick(ms_tick),
            .cs_tick(cs_tick),
            .delay(stage_cfg_q[g][`ASM_STG_DLY_LSB+7:`ASM_STG_DLY_LSB]),
            .hold(stage_cfg_q[g][`ASM_STG_HOLD_LSB+7:`ASM_STG_HOLD_LSB]),
            .trip(trip[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // output matrix with latches
   // ---------------------------------------------------------------
   reg [4:0] out_q;
   reg [4:0] latched_q;
   reg [4:0] drive;
   integer o;
   integer ol;
   integer ov;

   always @* begin
      for (o = 0; o < 5; o = o + 1) begin
         drive[o] = |(out_cfg_q[o][7:0] & trip);
      end
   end

   always @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         latched_q <= 5'h00;
         out_q <= 5'h00;
      end else begin
         for (ol = 0; ol < 5; ol = ol + 1) begin
            if (drive[ol] && out_cfg_q[ol][`ASM_OUT_LATCH]) begin
               latched_q[ol] <= 1'b1;
            end else if (clear_q || ack_s) begin
               latched_q[ol] <= 1'b0;
            end
         end
         out_q <= drive | latched_q;
      end
   end
   assign trip_outputs = out_q[3:0];
   assign alarm_relay_output = out_q[4];

   // ---------------------------------------------------------------
   // events: ph, res, sensor 1-2, stage 1-8 as ids 0..11
   // ---------------------------------------------------------------
   reg [11:0] ev_prev_q;
   reg [11:0] pend_on_q;
   reg [11:0] pend_off_q;
   reg ev_valid_q;
   reg [3:0] ev_id_q;
   reg ev_on_q;
   reg [11:0] take_on;
   reg [11:0] take_off;
   reg pick;
   integer e;
   integer ec;
   integer er;
   wire [11:0] ev_sig;

   assign ev_sig = {trip, light_ok[1:0], res_flag_q, ph_flag_q};

   // lowest id first, activation ahead of deactivation
   always @* begin
      take_on = 12'h000;
      take_off = 12'h000;
      pick = 1'b0;
      for (e = 0; e < 12; e = e + 1) begin
         if (!pick && pend_on_q[e]) begin
            take_on[e] = 1'b1;
            pick = 1'b1;
         end else if (!pick && pend_off_q[e]) begin
            take_off[e] = 1'b1;
            pick = 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         ev_prev_q <= 12'h000;
         pend_on_q <= 12'h000;
         pend_off_q <= 12'h000;
         ev_valid_q <= 1'b0;
         ev_id_q <= 4'h0;
         ev_on_q <= 1'b0;
      end else begin
         ev_prev_q <= ev_sig;
         // a new edge wins over the emission that clears the same bit
         pend_on_q <= (pend_on_q & ~take_on) |
            (ev_sig & ~ev_prev_q & evt_en_q[11:0]);
         pend_off_q <= (pend_off_q & ~take_off) |
            (~ev_sig & ev_prev_q & evt_en_q[`ASM_EVT_OFF_LSB+11:`ASM_EVT_OFF_LSB]);
         ev_valid_q <= pick;
         ev_on_q <= |take_on;
         for (ec = 0; ec < 12; ec = ec + 1) begin
            if (take_on[ec] || take_off[ec]) begin
               ev_id_q <= ec[3:0];
            end
         end
      end
   end
   assign event_valid = ev_valid_q;
   assign event_id = ev_id_q;
   assign event_on = ev_on_q;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   reg aw_q;
   reg w_q;
   reg [AW-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;
   reg [31:0] rd;
   reg rd_ok;
   wire wr_fire;
   wire [2:0] w_reg;
   wire [2:0] w_idx;
   wire w_ok;
   wire [31:0] m;

   function [9:0] clamp;
      input [31:0] v;
      input [9:0] lo;
      input [9:0] hi;
      begin
         clamp = (v[31:10] != 22'h000000 || v[9:0] > hi) ? hi :
            ((v[9:0] < lo) ? lo : v[9:0]);
      end
   endfunction

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready = !w_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign wr_fire = aw_q && w_q && !bvalid_q;
   assign w_reg = awaddr_q[7:5];
   assign w_idx = awaddr_q[4:2];
   assign w_ok = (awaddr_q[AW-1:8] == 0) && ((w_reg == `ASM_REGION_MISC && w_idx < 3'h5) ||
      (w_reg > `ASM_REGION_MISC && w_reg < `ASM_REGION_OUT) ||
      (w_reg == `ASM_REGION_OUT && w_idx < 3'h5));
   assign m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   always @* begin
      rd = 32'h00000000;
      rd_ok = (s_axi_araddr[AW-1:8] == 0);
      case ({s_axi_araddr[7:5], 2'b00})
         5'h00: begin
            case (s_axi_araddr[4:2])
               3'h0: rd[`ASM_CTRL_BUSY] = installing_q;
               3'h1: rd[9:0] = ph_start_q;
               3'h2: rd[9:0] = res_start_q;
               3'h3: rd[9:0] = sens_q;
               3'h4: rd = evt_en_q;
               3'h5: rd[14:0] = {res_flag_q, ph_flag_q, out_q, trip};
               3'h6: rd[9:0] = installed_q;
               default: rd_ok = 1'b0;
            endcase
         end
         5'h04: rd[23:0] = stage_cfg_q[s_axi_araddr[4:2]];
         5'h08: rd[16:0] = cur_sel_q[s_axi_araddr[4:2]];
         5'h0C: rd[24:0] = light_sel_q[s_axi_araddr[4:2]];
         5'h10: begin
            if (s_axi_araddr[4:2] < 3'h5) begin
               rd[8:0] = out_cfg_q[s_axi_araddr[4:2]];
            end else begin
               rd_ok = 1'b0;
            end
         end
         5'h14: begin
            for (ov = 0; ov < 5; ov = ov + 1) begin
               rd[ov] = out_cfg_q[ov][s_axi_araddr[4:2]];
            end
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge clk or negedge rst_l) begin
      if (!rst_l) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= {AW{1'b0}};
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
         rvalid_q <= 1'b0;
         rresp_q <= 2'b00;
         rdata_q <= 32'h00000000;
         ph_start_q <= `ASM_PH_START_RST;
         res_start_q <= `ASM_RES_START_RST;
         sens_q <= `ASM_SENS_RST;
         evt_en_q <= `ASM_EVT_EN_RST;
         clear_q <= 1'b0;
         install_req_q <= 1'b0;
         for (er = 0; er < 8; er = er + 1) begin
            stage_cfg_q[er] <= {`ASM_HOLD_RST, `ASM_DLY_RST, 8'h00};
            cur_sel_q[er] <= 17'h00000;
            light_sel_q[er] <= 25'h0000000;
         end
         for (er = 0; er < 5; er = er + 1) begin
            out_cfg_q[er] <= 9'h000;
         end
      end else begin
         clear_q <= 1'b0;
         install_req_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= w_ok ? 2'b00 : 2'b10;
            if (w_ok) begin
               case (w_reg)
                  `ASM_REGION_MISC: begin
                     case (w_idx)
                        3'h0: begin
                           install_req_q <= wdata_q[`ASM_CTRL_INSTALL] & wstrb_q[0];
                           clear_q <= wdata_q[`ASM_CTRL_CLEAR] & wstrb_q[0];
                        end
                        3'h1: ph_start_q <= clamp((wdata_q & m) | ({22'h0, ph_start_q} & ~m),
                           `ASM_PH_MIN, `ASM_PH_MAX);
                        3'h2: res_start_q <= clamp((wdata_q & m) | ({22'h0, res_start_q} & ~m),
                           `ASM_RES_MIN, `ASM_RES_MAX);
                        3'h3: sens_q <= clamp((wdata_q & m) | ({22'h0, sens_q} & ~m),
                           `ASM_SENS_MIN, `ASM_SENS_MAX);
                        default: evt_en_q <= ((wdata_q & m) | (evt_en_q & ~m)) &
                           `ASM_EVT_EN_RST;
                     endcase
                  end
                  `ASM_REGION_STAGE: begin
                     stage_cfg_q[w_idx] <= ((wdata_q[23:0] & m[23:0]) |
                        (stage_cfg_q[w_idx] & ~m[23:0])) & 24'hFFFF01;
                     // a hold below the minimum is raised to it
                     if (m[`ASM_STG_HOLD_LSB] &&
                        wdata_q[`ASM_STG_HOLD_LSB+7:`ASM_STG_HOLD_LSB] < `ASM_HOLD_MIN) begin
                        stage_cfg_q[w_idx][`ASM_STG_HOLD_LSB+7:`ASM_STG_HOLD_LSB] <=
                           `ASM_HOLD_MIN;
                     end
                  end
                  `ASM_REGION_CUR: cur_sel_q[w_idx] <= (wdata_q[16:0] & m[16:0]) |
                     (cur_sel_q[w_idx] & ~m[16:0]);
                  `ASM_REGION_LIGHT: light_sel_q[w_idx] <= (wdata_q[24:0] & m[24:0]) |
                     (light_sel_q[w_idx] & ~m[24:0]);
                  default: out_cfg_q[w_idx] <= (wdata_q[8:0] & m[8:0]) |
                     (out_cfg_q[w_idx] & ~m[8:0]);
               endcase
            end
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd : 32'h00000000;
            rresp_q <= rd_ok ? 2'b00 : 2'b10;
         end
      end
   end
endmodule // asm_top

// ==== hw/asm_regs.vh ====
// register offsets, field positions, reset values and timing counts of the arc stage matrix
`ifndef ASM_REGS_VH
`define ASM_REGS_VH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define ASM_CTRL 8'h00
`define ASM_PH_START 8'h04
`define ASM_RES_START 8'h08
`define ASM_LOOP_SENS 8'h0C
`define ASM_EVT_EN 8'h10
`define ASM_STATUS 8'h14
`define ASM_INSTALLED 8'h18
`define ASM_REGION_MISC 3'h0
`define ASM_REGION_STAGE 3'h1
`define ASM_REGION_CUR 3'h2
`define ASM_REGION_LIGHT 3'h3
`define ASM_REGION_OUT 3'h4
`define ASM_REGION_VIEW 3'h5

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define ASM_CTRL_INSTALL 0
`define ASM_CTRL_CLEAR 1
`define ASM_CTRL_BUSY 8
`define ASM_STG_EN 0
`define ASM_STG_DLY_LSB 8
`define ASM_STG_HOLD_LSB 16
`define ASM_OUT_LATCH 8
`define ASM_EVT_OFF_LSB 16

// ---------------------------------------------------------------
// reset values and ranges (current levels in units of 0.01 x nominal)
// ---------------------------------------------------------------
`define ASM_PH_START_RST 10'h064
`define ASM_PH_MIN 10'h032
`define ASM_PH_MAX 10'h320
`define ASM_RES_START_RST 10'h064
`define ASM_RES_MIN 10'h00A
`define ASM_RES_MAX 10'h1F4
`define ASM_SENS_RST 10'h2E1
`define ASM_SENS_MIN 10'h064
`define ASM_SENS_MAX 10'h384
`define ASM_DLY_RST 8'h00
`define ASM_HOLD_RST 8'h02
`define ASM_HOLD_MIN 8'h02
`define ASM_EVT_EN_RST 32'h0FFF0FFF

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ASM_CLK_NS 10
`define ASM_MS_NS 1000000
`define ASM_MS_CYC (`ASM_MS_NS / `ASM_CLK_NS)
`define ASM_HOLD_UNIT_MS 10
`define ASM_INSTALL_NS 100000
`define ASM_INSTALL_CYC (`ASM_INSTALL_NS / `ASM_CLK_NS)

`endif

// ==== hw/asm_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module asm_sync #(
   parameter W = 1
) (
   clk,
   rst_n,
   pin,
   sync
);
   input wire clk;
   input wire rst_n;
   input wire [W-1:0] pin;
   output wire [W-1:0] sync;

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] out_q;
   integer i;

   // s1 feeds s2 only; a bit moves once s2 and s3 agree
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         out_q <= {W{1'b0}};
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < W; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               out_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign sync = out_q;
endmodule // asm_sync

// ==== hw/asm_stage.v ====
// one arc stage: enable, trip delay in ms and minimum trip pulse in 10 ms units
`timescale 1ns/10ps
module asm_stage (
   clk,
   rst_n,
   enable,
   act,
   ms_tick,
   cs_tick,
   delay,
   hold,
   trip
);
   input wire clk;
   input wire rst_n;
   input wire enable;
   input wire act;
   input wire ms_tick;
   input wire cs_tick;
   input wire [7:0] delay;
   input wire [7:0] hold;
   output wire trip;

   reg [7:0] dcnt_q;
   reg [8:0] hcnt_q;
   reg trip_q;
   wire live;
   wire fire;

   assign live = enable & act;
   assign fire = live & (dcnt_q >= delay);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dcnt_q <= 8'h00;
         hcnt_q <= 9'h000;
         trip_q <= 1'b0;
      end else begin
         if (!live) begin
            dcnt_q <= 8'h00;
         end else if (ms_tick && dcnt_q < delay) begin
            dcnt_q <= dcnt_q + 8'h01;
         end
         // one extra unit so a partial first tick never shortens the pulse
         if (fire) begin
            hcnt_q <= {1'b0, hold} + 9'h001;
         end else if (cs_tick && hcnt_q != 9'h000) begin
            hcnt_q <= hcnt_q - 9'h001;
         end
         trip_q <= enable & (fire | (hcnt_q != 9'h000));
      end
   end

   assign trip = trip_q;
endmodule // asm_stage

// ==== test/asm_chk.sv ====
// bus handshake and event code checker of the arc stage matrix
`timescale 1ns/10ps
module asm_chk #(
   parameter AW = 12
) (
   input wire clk,
   input wire rst_n,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire trip_outputs_0,
   input wire event_valid,
   input wire [3:0] event_id,
   input wire event_on
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdone: assert property (p_bdone) else $error("write answer repeated");
   property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_wbusy: assert property (p_wbusy) else $error("write taken while answering");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer changed early");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdone: assert property (p_rdone) else $error("read answer repeated");
   property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read taken while answering");
   property p_rcause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   a_rcause: assert property (p_rcause) else $error("read answer without request");
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[AW-1:8] != 0
         |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_evid; event_valid |-> event_id < 4'hC; endproperty
   a_evid: assert property (p_evid) else $error("event code out of range");
   c_trip: cover property ($rose(trip_outputs_0));
   c_evon: cover property (event_valid && event_on);
   c_unmap: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // asm_chk
bind asm_top asm_chk #(.AW(AW)) u_chk (.clk, .rst_n, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .trip_outputs_0(trip_outputs[0]), .event_valid, .event_id, .event_on);

// ==== test/asm_far.sv ====
// far-side model: light sensors reporting light and presence
`timescale 1ns/10ps
module asm_far (
   input wire clk,
   input wire [9:0] lit,
   output logic [9:0] light_pin,
   output wire [9:0] sensor_present_pin
);
   initial light_pin = 10'h000;
   assign sensor_present_pin = 10'h003; // only sensors one and two fitted
   always @(posedge clk) light_pin <= lit;
endmodule // asm_far

// ==== test/tb.sv ====
// self-checking bench of the arc stage matrix
`timescale 1ns/10ps
`include "asm_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
   logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ack = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, d;
   logic [9:0] lit = 10'h000, ph = 10'h000;
   logic bready = 1'b0, rready = 1'b0;
   logic [1:0] r, br;
   logic [15:0] on_seen = 16'h0000, off_seen = 16'h0000;
   wire awready, wready, bvalid, arready, rvalid, evv, evon, alarm;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] trip, evid;
   wire [9:0] lpin, ppin;
   int err_total = 0, total_checks = 0;
   always #5 clk = ~clk;
   // short ms tick keeps hold times to a few hundred cycles
   asm_top #(.MS_CYC(10), .INSTALL_CYC(8)) dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .phase_mag(ph), .resid_mag(ph), .loop_level(ph), .goose_in(1'b0),
      .virtual_out(6'h00), .light_pin(lpin), .sensor_present_pin(ppin), .ack_pin(ack),
      .trip_outputs(trip), .alarm_relay_output(alarm), .event_valid(evv), .event_id(evid),
      .event_on(evon));
   asm_far far (.clk(clk), .lit(lit), .light_pin(lpin), .sensor_present_pin(ppin));
   // event pulses stand one cycle, so each is caught exactly once here
   always @(posedge clk) if (evv && evon) on_seen[evid] <= 1'b1;
   always @(posedge clk) if (evv && !evon) off_seen[evid] <= 1'b1;
   // ------------------------------------------------------------
   // bus tasks and scenarios
   // ------------------------------------------------------------
   task wr(input [11:0] a, input [31:0] v);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin br = bresp; break; end
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input [11:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin d = rdata; r = rresp; break; end
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task t_reset;
      rd(`ASM_EVT_EN); `CHK("evt_en", `ASM_EVT_EN_RST, d)
      rd(`ASM_LOOP_SENS); `CHK("loop_sens", 32'h2E1, d)
      rd(`ASM_RES_START); `CHK("res_start", 32'h64, d)
      rd(12'h020); `CHK("stage_cfg", 32'h00020000, d)
      rd(12'h100); `CHK("unmapped_resp", 2'h2, r)
      wr(12'h100, 32'h1); `CHK("wr_unmapped", 2'h2, br)
      $display("test reset done");
   endtask
   task t_light;
      wr(`ASM_CTRL, 32'h1); `CHK("wr_ok", 2'h0, br)
      rd(`ASM_CTRL); `CHK("installing", 1'b1, d[8])
      repeat (20) @(posedge clk);
      rd(`ASM_INSTALLED); `CHK("installed", 32'h3, d)
      wr(12'h060, 32'h1); wr(12'h080, 32'h101); wr(12'h084, 32'h2);
      lit <= 10'h001; repeat (12) @(posedge clk);
      `CHK("t1_disabled", 1'b0, trip[0])
      wr(12'h020, 32'h00020001); repeat (12) @(posedge clk);
      `CHK("t1_light_only", 1'b1, trip[0])
      rd(12'h0A0); `CHK("view", 32'h1, d)
      $display("test light done");
   endtask
   task t_and;
      wr(12'h044, 32'h1); wr(12'h064, 32'h2); wr(12'h024, 32'h00020001);
      wr(12'h090, 32'h2);
      lit <= 10'h003; repeat (12) @(posedge clk);
      `CHK("t2_light_no_cur", 1'b0, trip[1])
      ph <= 10'h0C8; repeat (12) @(posedge clk);
      `CHK("t2_both", 1'b1, trip[1])
      `CHK("a1_alarm", 1'b1, alarm)
      rd(`ASM_STATUS); `CHK("status", 32'h7303, d)
      `CHK("ev_on", 16'h003F, on_seen)
      $display("test and done");
   endtask
   task t_latch;
      lit <= 10'h000; ph <= 10'h000; repeat (150) @(posedge clk);
      `CHK("t2_min_hold", 1'b1, trip[1])
      repeat (300) @(posedge clk);
      `CHK("t2_released", 1'b0, trip[1])
      `CHK("a1_released", 1'b0, alarm)
      `CHK("t1_latched", 1'b1, trip[0])
      `CHK("ev_off", 16'h003F, off_seen)
      ack <= 1'b1; repeat (10) @(posedge clk);
      `CHK("t1_acked", 1'b0, trip[0])
      ack <= 1'b0; lit <= 10'h001; repeat (12) @(posedge clk);
      lit <= 10'h000; repeat (320) @(posedge clk);
      `CHK("t1_relatched", 1'b1, trip[0])
      wr(`ASM_CTRL, 32'h2); repeat (2) @(posedge clk);
      `CHK("t1_cleared", 1'b0, trip[0])
      $display("test latch done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset; t_light; t_and; t_latch;
      end_sim;
   end
   initial begin
      #100000;
      err_total++;
      end_sim;
   end
endmodule // tb
